// ===== gpio_line_ctrl.sv
`timescale 1ns/1ns

// How it works
// - Detected level change sets line's status bit
// - Status read and reset clear change bits
// - Open-drain enable write sets flagged lines
// - Open-drain disable write clears flagged lines
// - Open-drain line drives low only; reads 1
// - Normal line drives both levels; reads 0
// - Pull-up disable write turns flagged pull-ups off
// - Pull-up enable write turns flagged pull-ups on
// - Pull-up state reads 0 when pull-up on
// - Function A write routes flagged lines to A
// - Function B write routes flagged lines to B
// - Selection state reads 0 A, 1 B
// - Direct-write enable/disable set and clear permission
// - Permitted lines take direct output data writes
// - Unpermitted lines ignore direct output data writes
// - Output data bit is level driven out on lines not in peripheral mode
module gpio_line_ctrl
  import gpio_line_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] pad_in,
  output logic [31:0] pad_out,
  output logic [31:0] pad_oe,
  output logic [31:0] pad_pullup,
  input wire logic [31:0] func_a_out,
  input wire logic [31:0] func_a_oe,
  input wire logic [31:0] func_b_out,
  input wire logic [31:0] func_b_oe,
  output logic [31:0] func_in,
  output logic change_irq
);

  function automatic logic [31:0] set_clear(input logic [31:0] cur, input logic [31:0] set_m,
                                            input logic [31:0] clr_m);
    set_clear = (cur | set_m) & ~clr_m;
  endfunction

  // Registers
  logic [31:0] change_status_reg;
  logic [31:0] change_irq_enable_reg;
  logic [31:0] output_enable_reg;
  logic [31:0] peripheral_mode_reg;
  logic [31:0] output_level_reg;
  logic [31:0] open_drain_reg;
  logic [31:0] pullup_off_reg;
  logic [31:0] function_b_reg;
  logic [31:0] direct_write_reg;

  // Pin synchroniser and filtered level
  logic [31:0] sync1_reg;
  logic [31:0] sync2_reg;
  logic [31:0] sync3_reg;
  logic [31:0] line_level_reg;
  logic level_valid_reg;

  // Bus outputs
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;

  // Pin outputs
  logic [31:0] pad_out_reg;
  logic [31:0] pad_oe_reg;
  logic [31:0] pad_pullup_reg;
  logic change_irq_reg;

  // Bus decode
  wire access = psel & penable;
  wire done = access & pready_reg;
  wire wr_done = done & pwrite;
  wire rd_done = done & ~pwrite;

  wire hit_status = paddr == OFF_INPUT_CHANGE_STATUS;
  wire hit_clear = paddr == OFF_CHANGE_CLEAR;
  wire hit_irq_en = paddr == OFF_CHANGE_IRQ_ENABLE;
  wire hit_oe = paddr == OFF_LINE_OUTPUT_ENABLE;
  wire hit_mode = paddr == OFF_PERIPHERAL_MODE;
  wire hit_level = paddr == OFF_OUTPUT_LEVEL_REGISTER;
  wire hit_pin = paddr == OFF_LINE_LEVEL;
  wire hit_od_en = paddr == OFF_OPEN_DRAIN_ENABLE;
  wire hit_od_dis = paddr == OFF_OPEN_DRAIN_DISABLE;
  wire hit_od_st = paddr == OFF_OPEN_DRAIN_STATE;
  wire hit_pu_dis = paddr == OFF_PULLUP_DISABLE;
  wire hit_pu_en = paddr == OFF_PULLUP_ENABLE;
  wire hit_pu_st = paddr == OFF_PULLUP_STATE;
  wire hit_fa = paddr == OFF_FUNCTION_A_SELECT;
  wire hit_fb = paddr == OFF_FUNCTION_B_SELECT;
  wire hit_fs_st = paddr == OFF_FUNCTION_SELECT_STATE;
  wire hit_dw_en = paddr == OFF_DIRECT_WRITE_ENABLE;
  wire hit_dw_dis = paddr == OFF_DIRECT_WRITE_DISABLE;
  wire hit_dw_st = paddr == OFF_DIRECT_WRITE_STATE;

  wire hit_any = hit_status | hit_clear | hit_irq_en | hit_oe | hit_mode | hit_level |
                 hit_pin | hit_od_en | hit_od_dis | hit_od_st | hit_pu_dis | hit_pu_en |
                 hit_pu_st | hit_fa | hit_fb | hit_fs_st | hit_dw_en | hit_dw_dis | hit_dw_st;
  // Write to a read-only word or an unmapped word is flagged as an error
  wire read_only_hit = hit_status | hit_pin | hit_od_st | hit_pu_st | hit_fs_st | hit_dw_st;
  wire bad_access = ~hit_any | (pwrite & read_only_hit);

  wire [31:0] wmask_od_en = (wr_done & hit_od_en) ? pwdata : RST_ZERO;
  wire [31:0] wmask_od_dis = (wr_done & hit_od_dis) ? pwdata : RST_ZERO;
  wire [31:0] wmask_pu_dis = (wr_done & hit_pu_dis) ? pwdata : RST_ZERO;
  wire [31:0] wmask_pu_en = (wr_done & hit_pu_en) ? pwdata : RST_ZERO;
  wire [31:0] wmask_fa = (wr_done & hit_fa) ? pwdata : RST_ZERO;
  wire [31:0] wmask_fb = (wr_done & hit_fb) ? pwdata : RST_ZERO;
  wire [31:0] wmask_dw_en = (wr_done & hit_dw_en) ? pwdata : RST_ZERO;
  wire [31:0] wmask_dw_dis = (wr_done & hit_dw_dis) ? pwdata : RST_ZERO;
  wire [31:0] wmask_chg_clr = (wr_done & hit_clear) ? pwdata : RST_ZERO;

  // Only bits already reported in the latched read data are cleared,
  // so a change arriving during the wait cycle is not lost.
  wire [31:0] read_clear = (rd_done & hit_status) ? prdata_reg : RST_ZERO;

  // Change detection: level accepted once stages two and three agree
  wire [31:0] stable = ~(sync2_reg ^ sync3_reg);
  wire [31:0] change_evt = level_valid_reg ? (stable & (sync3_reg ^ line_level_reg)) : RST_ZERO;
  wire [31:0] level_next = level_valid_reg ?
                           ((line_level_reg & ~stable) | (sync3_reg & stable)) : sync3_reg;

  wire [31:0] open_drain_next = set_clear(open_drain_reg, wmask_od_en,
                                          wmask_od_dis);
  wire [31:0] pullup_off_next = set_clear(pullup_off_reg, wmask_pu_dis,
                                          wmask_pu_en);
  wire [31:0] function_b_next = set_clear(function_b_reg, wmask_fb, wmask_fa);
  wire [31:0] direct_write_next = set_clear(direct_write_reg, wmask_dw_en,
                                            wmask_dw_dis);
  // Set wins over both clears
  wire [31:0] change_status_next = (change_status_reg & ~(read_clear | wmask_chg_clr)) |
                                   change_evt;

  wire [31:0] level_write = (wr_done & hit_level) ? direct_write_reg : RST_ZERO;
  wire [31:0] output_level_next = (output_level_reg & ~level_write) |
                                  (pwdata & level_write);

  // Pad multiplexing
  wire [31:0] drive_data = (peripheral_mode_reg & function_b_reg & func_b_out) |
                           (peripheral_mode_reg & ~function_b_reg & func_a_out) |
                           (~peripheral_mode_reg & output_level_reg);
  wire [31:0] drive_en = (peripheral_mode_reg & function_b_reg & func_b_oe) |
                         (peripheral_mode_reg & ~function_b_reg & func_a_oe) |
                         (~peripheral_mode_reg & output_enable_reg);
  // Open-drain lines release the pad instead of driving high
  wire [31:0] pad_oe_next = drive_en & (~open_drain_reg | ~drive_data);
  wire [31:0] pad_out_next = drive_data & ~open_drain_reg;

  logic [31:0] read_value;
  always_comb begin
    read_value = RST_ZERO;
    if (hit_status) read_value = change_status_reg;
    if (hit_irq_en) read_value = change_irq_enable_reg;
    if (hit_oe) read_value = output_enable_reg;
    if (hit_mode) read_value = peripheral_mode_reg;
    if (hit_level) read_value = output_level_reg;
    if (hit_pin) read_value = line_level_reg;
    if (hit_od_st) read_value = open_drain_reg;
    if (hit_pu_st) read_value = pullup_off_reg;
    if (hit_fs_st) read_value = function_b_reg;
    if (hit_dw_st) read_value = direct_write_reg;
  end

  always_ff @(posedge ref_clk) begin
    sync1_reg <= pad_in;
    sync2_reg <= sync1_reg;
    sync3_reg <= sync2_reg;
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= RST_ZERO;
    end else begin
      pready_reg <= access & ~pready_reg;
      pslverr_reg <= access & ~pready_reg & bad_access;
      prdata_reg <= (access & ~pready_reg & ~pwrite) ? read_value : RST_ZERO;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      change_status_reg <= RST_ZERO;
      change_irq_enable_reg <= RST_ZERO;
      output_enable_reg <= RST_OUTPUT_ENABLE;
      peripheral_mode_reg <= RST_PERIPHERAL_MODE;
      output_level_reg <= RST_OUTPUT_LEVEL;
      open_drain_reg <= RST_OPEN_DRAIN;
      pullup_off_reg <= RST_PULLUP_OFF;
      function_b_reg <= RST_FUNCTION_B;
      direct_write_reg <= RST_DIRECT_WRITE;
      line_level_reg <= RST_ZERO;
      level_valid_reg <= 1'b0;
    end else begin
      change_status_reg <= change_status_next;
      if (wr_done & hit_irq_en) change_irq_enable_reg <= pwdata;
      if (wr_done & hit_oe) output_enable_reg <= pwdata;
      if (wr_done & hit_mode) peripheral_mode_reg <= pwdata;
      output_level_reg <= output_level_next;
      open_drain_reg <= open_drain_next;
      pullup_off_reg <= pullup_off_next;
      function_b_reg <= function_b_next;
      direct_write_reg <= direct_write_next;
      line_level_reg <= level_next;
      level_valid_reg <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pad_out_reg <= RST_ZERO;
      pad_oe_reg <= RST_ZERO;
      pad_pullup_reg <= ~RST_PULLUP_OFF;
      change_irq_reg <= 1'b0;
    end else begin
      pad_out_reg <= pad_out_next;
      pad_oe_reg <= pad_oe_next;
      pad_pullup_reg <= ~pullup_off_reg;
      change_irq_reg <= |(change_status_reg & change_irq_enable_reg);
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign pad_out = pad_out_reg;
  assign pad_oe = pad_oe_reg;
  assign pad_pullup = pad_pullup_reg;
  assign func_in = line_level_reg;
  assign change_irq = change_irq_reg;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  property p_change_sets;
    change_evt != RST_ZERO |=> (change_status_reg & $past(change_evt)) == $past(change_evt);
  endproperty
  a_change_sets: assert property (p_change_sets) else $error("change not latched");

  property p_read_clears;
    (rd_done && hit_status && change_evt == RST_ZERO) |=>
      (change_status_reg & $past(prdata_reg)) == RST_ZERO;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("read did not clear");

  property p_od_enable;
    (wr_done && hit_od_en) |=>
      open_drain_reg == ($past(open_drain_reg) | $past(pwdata));
  endproperty
  a_od_enable: assert property (p_od_enable) else $error("open-drain enable wrong");

  property p_od_disable;
    (wr_done && hit_od_dis) |=>
      open_drain_reg == ($past(open_drain_reg) & ~$past(pwdata));
  endproperty
  a_od_disable: assert property (p_od_disable) else $error("open-drain disable wrong");

  property p_od_low_only;
    ##1 (pad_oe_reg & pad_out_reg & $past(open_drain_reg)) == RST_ZERO;
  endproperty
  a_od_low_only: assert property (p_od_low_only) else $error("open-drain drove high");

  property p_push_pull;
    ##1 ((pad_out_reg ^ $past(drive_data)) & $past(~open_drain_reg)) == RST_ZERO;
  endproperty
  a_push_pull: assert property (p_push_pull) else $error("push-pull data wrong");

  property p_pullup_pin;
    (wr_done && (hit_pu_en || hit_pu_dis)) |=> ##1 pad_pullup_reg == ~$past(pullup_off_next, 2);
  endproperty
  a_pullup_pin: assert property (p_pullup_pin) else $error("pull-up pin wrong");

  property p_pullup_read;
    (access && !pready_reg && !pwrite && hit_pu_st) |=> prdata_reg == $past(pullup_off_reg);
  endproperty
  a_pullup_read: assert property (p_pullup_read) else $error("pull-up state wrong");

  property p_func_select;
    (wr_done && (hit_fa || hit_fb)) |=> function_b_reg ==
      ($past(hit_fb) ? ($past(function_b_reg) | $past(pwdata))
                     : ($past(function_b_reg) & ~$past(pwdata)));
  endproperty
  a_func_select: assert property (p_func_select) else $error("select wrong");

  property p_direct_write;
    (wr_done && hit_level) |=> output_level_reg ==
      (($past(output_level_reg) & ~$past(direct_write_reg)) |
       ($past(pwdata) & $past(direct_write_reg)));
  endproperty
  a_direct_write: assert property (p_direct_write) else $error("write lost");

  property p_dw_perm;
    (wr_done && hit_dw_en) |=> (direct_write_reg & $past(pwdata)) == $past(pwdata);
  endproperty
  a_dw_perm: assert property (p_dw_perm) else $error("permission not set");

  property p_answer;
    (access && !pready_reg) |=> pready_reg ##1 !pready_reg;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer timing wrong");

  property p_error_flag;
    (access && !pready_reg && bad_access) |=> pslverr_reg && pready_reg;
  endproperty
  a_error_flag: assert property (p_error_flag) else $error("error not flagged");

  property p_wo_zero;
    (access && !pready_reg && !pwrite && (hit_clear || hit_od_en || hit_od_dis || hit_pu_dis ||
      hit_pu_en || hit_fa || hit_fb || hit_dw_en || hit_dw_dis)) |=> prdata_reg == RST_ZERO;
  endproperty
  a_wo_zero: assert property (p_wo_zero) else $error("write-only nonzero");

  property p_pu_disable;
    (wr_done && hit_pu_dis) |=> pullup_off_reg == ($past(pullup_off_reg) | $past(pwdata));
  endproperty
  a_pu_disable: assert property (p_pu_disable) else $error("pull-up disable wrong");

  property p_pu_enable;
    (wr_done && hit_pu_en) |=> pullup_off_reg == ($past(pullup_off_reg) & ~$past(pwdata));
  endproperty
  a_pu_enable: assert property (p_pu_enable) else $error("pull-up enable wrong");

  property p_dw_forbid;
    (wr_done && hit_dw_dis) |=> (direct_write_reg & $past(pwdata)) == RST_ZERO;
  endproperty
  a_dw_forbid: assert property (p_dw_forbid) else $error("permission not cleared");

  property p_func_read;
    (access && !pready_reg && !pwrite && hit_fs_st) |=> prdata_reg == $past(function_b_reg);
  endproperty
  a_func_read: assert property (p_func_read) else $error("selection state wrong");

  property p_od_read;
    (access && !pready_reg && !pwrite && hit_od_st) |=> prdata_reg == $past(open_drain_reg);
  endproperty
  a_od_read: assert property (p_od_read) else $error("open-drain state wrong");

  property p_od_hold;
    !(wr_done && (hit_od_en || hit_od_dis)) |=> $stable(open_drain_reg);
  endproperty
  a_od_hold: assert property (p_od_hold) else $error("open-drain moved");

  property p_level_hold;
    !(wr_done && hit_level) |=> $stable(output_level_reg);
  endproperty
  a_level_hold: assert property (p_level_hold) else $error("output level moved");

  property p_func_hold;
    !(wr_done && (hit_fa || hit_fb)) |=> $stable(function_b_reg);
  endproperty
  a_func_hold: assert property (p_func_hold) else $error("selection moved");

  property p_irq_level;
    ##1 change_irq_reg == |($past(change_status_reg) & $past(change_irq_enable_reg));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

  property p_status_read;
    (access && !pready_reg && !pwrite && hit_status) |=> prdata_reg == $past(change_status_reg);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status data wrong");

endmodule // gpio_line_ctrl

// ===== gpio_line_pkg.sv
package gpio_line_pkg;

  localparam int LINE_COUNT = 32;
  localparam int ADDR_WIDTH = 8;
  localparam int DATA_WIDTH = 32;

  // Register byte offsets
  localparam logic [7:0] OFF_INPUT_CHANGE_STATUS = 8'h00;
  localparam logic [7:0] OFF_CHANGE_CLEAR = 8'h04;
  localparam logic [7:0] OFF_CHANGE_IRQ_ENABLE = 8'h08;
  localparam logic [7:0] OFF_LINE_OUTPUT_ENABLE = 8'h0C;
  localparam logic [7:0] OFF_PERIPHERAL_MODE = 8'h10;
  localparam logic [7:0] OFF_OUTPUT_LEVEL_REGISTER = 8'h14;
  localparam logic [7:0] OFF_LINE_LEVEL = 8'h18;
  localparam logic [7:0] OFF_OPEN_DRAIN_ENABLE = 8'h20;
  localparam logic [7:0] OFF_OPEN_DRAIN_DISABLE = 8'h24;
  localparam logic [7:0] OFF_OPEN_DRAIN_STATE = 8'h28;
  localparam logic [7:0] OFF_PULLUP_DISABLE = 8'h30;
  localparam logic [7:0] OFF_PULLUP_ENABLE = 8'h34;
  localparam logic [7:0] OFF_PULLUP_STATE = 8'h38;
  localparam logic [7:0] OFF_FUNCTION_A_SELECT = 8'h40;
  localparam logic [7:0] OFF_FUNCTION_B_SELECT = 8'h44;
  localparam logic [7:0] OFF_FUNCTION_SELECT_STATE = 8'h48;
  localparam logic [7:0] OFF_DIRECT_WRITE_ENABLE = 8'h50;
  localparam logic [7:0] OFF_DIRECT_WRITE_DISABLE = 8'h54;
  localparam logic [7:0] OFF_DIRECT_WRITE_STATE = 8'h58;

  // Reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] RST_OPEN_DRAIN = 32'h0000_0000;
  localparam logic [31:0] RST_PULLUP_OFF = 32'h0000_0000;
  localparam logic [31:0] RST_FUNCTION_B = 32'h0000_0000;
  localparam logic [31:0] RST_DIRECT_WRITE = 32'h0000_0000;
  localparam logic [31:0] RST_OUTPUT_ENABLE = 32'h0000_0000;
  localparam logic [31:0] RST_PERIPHERAL_MODE = 32'h0000_0000;
  localparam logic [31:0] RST_OUTPUT_LEVEL = 32'h0000_0000;

  // Bus timing: access phase always takes one wait cycle
  localparam int APB_WAIT_CYCLES = 1;

endpackage

// ===== io_line_pad_and_function_control_tb.sv
`timescale 1ns/1ns

module io_line_pad_and_function_control_tb;
  import gpio_line_pkg::*;
  logic ref_clk, reset_n, psel, penable, pwrite, pready, pslverr, change_irq, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, pad_in, pad_out, pad_oe, pad_pullup, func_in;
  logic [31:0] func_a_out, func_a_oe, func_b_out, func_b_oe, ext_val, ext_en;
  logic [31:0] rd, v, w, m, odr, exp_val;
  logic [31:0] st_m [4];
  logic [7:0] set_a [4] = '{OFF_OPEN_DRAIN_ENABLE, OFF_PULLUP_DISABLE,
    OFF_FUNCTION_B_SELECT, OFF_DIRECT_WRITE_ENABLE};
  logic [7:0] clr_a [4] = '{OFF_OPEN_DRAIN_DISABLE, OFF_PULLUP_ENABLE,
    OFF_FUNCTION_A_SELECT, OFF_DIRECT_WRITE_DISABLE};
  logic [7:0] st_a [4] = '{OFF_OPEN_DRAIN_STATE, OFF_PULLUP_STATE,
    OFF_FUNCTION_SELECT_STATE, OFF_DIRECT_WRITE_STATE};
  logic [7:0] wo_a [9] = '{OFF_CHANGE_CLEAR, 8'h20, 8'h24, 8'h30, 8'h34, 8'h40, 8'h44,
    8'h50, 8'h54};
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  int k;

  gpio_line_ctrl dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe(pad_oe), .pad_pullup(pad_pullup), .func_a_out(func_a_out),
    .func_a_oe(func_a_oe), .func_b_out(func_b_out), .func_b_oe(func_b_oe),
    .func_in(func_in), .change_irq(change_irq));

  io_pad_model pad_u (.ref_clk(ref_clk), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup(pad_pullup), .ext_val(ext_val), .ext_en(ext_en), .pad_in(pad_in));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task report_and_stop;
    if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Whole-run ceiling, well above the roughly one thousand cycles the tests need
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // Wait as long as the slave needs; the run ceiling ends a hang
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] route(input logic [31:0] sel, input logic [31:0] b,
                                        input logic [31:0] a);
    return (sel & b) | (~sel & a);
  endfunction

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(name, exp, rd);
  endtask

  initial begin
    void'($urandom(32'hB408));
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    func_a_out = 32'h0000_0000;
    func_b_out = 32'h0000_0000;
    func_a_oe = 32'hFFFF_FFFF;
    func_b_oe = 32'hFFFF_FFFF;
    ext_val = 32'h0000_0000;
    ext_en = 32'hFFFF_FFFF;
    st_m = '{32'h0, 32'h0, 32'h0, 32'h0};
    odr = 32'h0000_0000;
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    chk("pad_pullup", 32'hFFFF_FFFF, pad_pullup);
    for (k = 0; k < 4; k++) rdc("state at reset", st_a[k], 32'h0000_0000);
    rdc("change status", OFF_INPUT_CHANGE_STATUS, 32'h0000_0000);
    for (k = 0; k < 9; k++) rdc("write-only", wo_a[k], 32'h0000_0000);
    wr(OFF_OPEN_DRAIN_STATE, 32'hFFFF_FFFF);
    chk("read-only error", 32'h1, {31'h0, err});
    rdc("read-only kept", OFF_OPEN_DRAIN_STATE, 32'h0000_0000);
    apb(1'b0, 8'hFC, 32'h0000_0000);
    chk("unmapped error", 32'h1, {31'h0, err});
    // Enable and disable words hit at random, with a shadow per register
    repeat (40) begin
      k = $urandom % 4;
      v = $urandom;
      if ($urandom % 2) begin
        wr(set_a[k], v);
        st_m[k] = st_m[k] | v;
      end else begin
        wr(clr_a[k], v);
        st_m[k] = st_m[k] & ~v;
      end
      rdc("state", st_a[k], st_m[k]);
      chk("pad_pullup", ~st_m[1], pad_pullup);
    end
    wr(OFF_LINE_OUTPUT_ENABLE, 32'hFFFF_FFFF);
    wr(OFF_PERIPHERAL_MODE, 32'h0000_0000);
    repeat (12) begin
      m = $urandom;
      v = $urandom;
      wr(OFF_DIRECT_WRITE_DISABLE, ~m);
      wr(OFF_DIRECT_WRITE_ENABLE, m);
      wr(OFF_OUTPUT_LEVEL_REGISTER, v);
      odr = (odr & ~m) | (v & m);
      rdc("output level", OFF_OUTPUT_LEVEL_REGISTER, odr);
      chk("driven high", odr & ~st_m[0], pad_out & pad_oe);
      chk("drive enable", ~st_m[0] | ~odr, pad_oe);
    end
    wr(OFF_PERIPHERAL_MODE, 32'hFFFF_FFFF);
    repeat (8) begin
      m = $urandom;
      wr(OFF_FUNCTION_B_SELECT, m);
      wr(OFF_FUNCTION_A_SELECT, ~m);
      func_a_out <= $urandom;
      func_b_out <= $urandom;
      func_a_oe <= $urandom;
      func_b_oe <= $urandom;
      rdc("function state", OFF_FUNCTION_SELECT_STATE, m);
      exp_val = route(m, func_b_out, func_a_out);
      w = route(m, func_b_oe, func_a_oe);
      chk("routed level", exp_val & w & ~st_m[0], pad_out & pad_oe);
      chk("routed enable", w & (~st_m[0] | ~exp_val), pad_oe);
    end
    wr(OFF_PERIPHERAL_MODE, 32'h0000_0000);
    wr(OFF_LINE_OUTPUT_ENABLE, 32'h0000_0000);
    repeat (6) @(posedge ref_clk);
    apb(1'b0, OFF_INPUT_CHANGE_STATUS, 32'h0000_0000);
    for (k = 0; k < 6; k++) begin
      m = $urandom;
      wr(OFF_CHANGE_IRQ_ENABLE, m);
      v = $urandom;
      w = $urandom;
      ext_val <= ext_val ^ v;
      repeat (8) @(posedge ref_clk);
      // Lines toggled twice must still report a change
      ext_val <= ext_val ^ w;
      repeat (8) @(posedge ref_clk);
      chk("irq", {31'h0, |((v | w) & m)}, {31'h0, change_irq});
      chk("func_in", ext_val, func_in);
      if (k % 2) begin
        wr(OFF_CHANGE_CLEAR, 32'hFFFF_FFFF);
        repeat (3) @(posedge ref_clk);
        chk("irq after clear", 32'h0, {31'h0, change_irq});
        rdc("status after clear", OFF_INPUT_CHANGE_STATUS, 32'h0000_0000);
      end else begin
        rdc("change status", OFF_INPUT_CHANGE_STATUS, v | w);
        rdc("status after read", OFF_INPUT_CHANGE_STATUS, 32'h0000_0000);
      end
    end
    rdc("line level", OFF_LINE_LEVEL, ext_val);
    // Outside driver let go: only the pull-ups hold the lines
    wr(OFF_PULLUP_ENABLE, 32'hFFFF_FFFF);
    ext_en <= 32'h0000_0000;
    repeat (8) @(posedge ref_clk);
    rdc("pulled level", OFF_LINE_LEVEL, 32'hFFFF_FFFF);
    report_and_stop();
  end
endmodule // io_line_pad_and_function_control_tb

// ===== io_pad_model.sv
`timescale 1ns/1ns

// Pads plus whatever else hangs on the wire outside the block
module io_pad_model (
  input wire logic ref_clk,
  input wire logic [31:0] pad_out,
  input wire logic [31:0] pad_oe,
  input wire logic [31:0] pad_pullup,
  input wire logic [31:0] ext_val,
  input wire logic [31:0] ext_en,
  output logic [31:0] pad_in
);
  logic [31:0] last_level;
  logic [31:0] idle_level;

  // Undriven, unpulled lines wander instead of holding their last level
  assign idle_level = pad_pullup | ~last_level;
  // Device drive wins over the outside driver
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val) |
                  (~pad_oe & ~ext_en & idle_level);

  always_ff @(posedge ref_clk) begin
    last_level <= pad_in;
  end
endmodule // io_pad_model
